// ---- three_wire_register_loader.sv ----
// Three-wire serial loader: shift register, load strobe, chip enable and lock output
`timescale 1ns/100ps
`default_nettype none
module three_wire_register_loader
  import loader_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic serial_data_i,
  input wire logic load_strobe_i,
  input wire logic chip_enable_i,
  input wire logic lock_detect_i,
  input wire logic [ADDR_W-1:0] reg_sel_i,
  output logic [WORD_W-1:0] reg_data_o,
  output logic load_done_o,
  output logic [ADDR_W-1:0] load_addr_o,
  output logic powered_up_o,
  output logic pump_output_oe_o,
  output logic lock_indicator_o
);
  logic [WORD_W-1:0] shift_word;
  logic [SYNC_BITS-1:0] pin_async;
  logic [SYNC_BITS-1:0] sync_meta;
  logic [SYNC_BITS-1:0] sync_out;
  logic load_prev;
  logic load_rise;
  load_state_t state;
  load_state_t next_state;
  logic [WORD_W-1:0] held_word;
  logic wr_en;
  logic pd_bit;
  logic ce_s;
  logic lock_s;

  // Serial clock domain: the only logic the link clock touches
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_word <= WORD_RESET;
    end else begin
      shift_word <= {shift_word[WORD_W-2:0], serial_data_i};
    end
  end

  // Pins from outside the mclk domain
  assign pin_async[SYNC_LOAD] = load_strobe_i;
  assign pin_async[SYNC_CE] = chip_enable_i;
  assign pin_async[SYNC_LOCK] = lock_detect_i;

  genvar b;
  generate
    for (b = 0; b < SYNC_BITS; b++) begin : g_sync
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          sync_meta[b] <= SYNC_RESET[b];
          sync_out[b] <= SYNC_RESET[b];
        end else begin
          sync_meta[b] <= pin_async[b];
          sync_out[b] <= sync_meta[b];
        end
      end
    end
  endgenerate

  assign ce_s = sync_out[SYNC_CE];
  assign lock_s = sync_out[SYNC_LOCK];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      load_prev <= 1'b0;
    end else begin
      load_prev <= sync_out[SYNC_LOAD];
    end
  end

  assign load_rise = sync_out[SYNC_LOAD] && !load_prev;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (load_rise) begin
          next_state = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        next_state = ST_WRITE;
      end
      ST_WRITE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Word is quasi-static here: the serial clock is idle once the strobe is high
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      held_word <= WORD_RESET;
    end else if (state == ST_CAPTURE) begin
      held_word <= shift_word;
    end
  end

  assign wr_en = (state == ST_WRITE);

  ctrl_reg_bank u_bank (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_en),
    .wr_addr_i(held_word[CTRL_MSB:CTRL_LSB]),
    .wr_data_i(held_word),
    .rd_addr_i(reg_sel_i),
    .rd_data_o(reg_data_o)
  );

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      load_done_o <= 1'b0;
      load_addr_o <= ADDR_RESET;
    end else begin
      load_done_o <= wr_en;
      if (wr_en) begin
        load_addr_o <= held_word[CTRL_MSB:CTRL_LSB];
      end
    end
  end

  // Shadow of the power-down bit so power control needs no read port
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_bit <= 1'b0;
    end else if (wr_en && held_word[CTRL_MSB:CTRL_LSB] == PD_REG) begin
      pd_bit <= held_word[PD_BIT];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      powered_up_o <= 1'b0;
      pump_output_oe_o <= 1'b0;
    end else begin
      powered_up_o <= ce_s && !pd_bit;
      pump_output_oe_o <= ce_s && !pd_bit;
    end
  end

  // A powered-down loop cannot claim lock
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_indicator_o <= 1'b0;
    end else begin
      lock_indicator_o <= lock_s && ce_s && !pd_bit;
    end
  end

  chk_shift_in: assert property (@(posedge sclk_i) disable iff (rst_i)
    ##1 shift_word == {$past(shift_word[WORD_W-2:0]), $past(serial_data_i)})
    else $error("shift register did not take serial data");

  chk_load_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state == ST_IDLE && load_rise) |-> ##2 (wr_en && held_word == $past(shift_word, 1)) ##1 load_done_o)
    else $error("strobe rise did not load the word");

  chk_load_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_en |=> load_addr_o == $past(held_word[CTRL_MSB:CTRL_LSB]))
    else $error("load went to the wrong register");

  chk_pump_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    !ce_s |=> !pump_output_oe_o && !powered_up_o)
    else $error("pump driven while chip disabled");

  chk_power_up: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_s && !pd_bit) |=> powered_up_o && pump_output_oe_o)
    else $error("device failed to power up");

  chk_pd_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    pd_bit |=> !powered_up_o)
    else $error("power-down bit ignored");

  chk_lock_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    !lock_s |=> !lock_indicator_o)
    else $error("lock shown after loss");

  chk_lock_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    (lock_s && ce_s && !pd_bit) [*2] |=> lock_indicator_o)
    else $error("lock not shown");

  cov_load: cover property (@(posedge mclk_i) disable iff (rst_i) load_done_o);
  cov_pd_write: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(pd_bit));
  cov_locked: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(lock_indicator_o));
  cov_ce_off: cover property (@(posedge mclk_i) disable iff (rst_i) $fell(powered_up_o));
endmodule : three_wire_register_loader
`default_nettype wire

// ---- loader_pkg.sv ----
// Shared constants and types for the three-wire register loader
`default_nettype none
package loader_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 3;
  localparam int REG_COUNT = 8;
  localparam int SYNC_BITS = 3;
  // Positions in the synchroniser vector
  localparam int SYNC_LOAD = 0;
  localparam int SYNC_CE = 1;
  localparam int SYNC_LOCK = 2;
  // Control field of a shifted word
  localparam int CTRL_LSB = 0;
  localparam int CTRL_MSB = 2;
  // Location of the power-down control bit
  localparam logic [ADDR_W-1:0] PD_REG = 3'h2;
  localparam int PD_BIT = 5;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 3'h0;
  localparam logic [SYNC_BITS-1:0] SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CAPTURE = 2'h1,
    ST_WRITE = 2'h3
  } load_state_t;
endpackage : loader_pkg
`default_nettype wire

// ---- ctrl_reg_bank.sv ----
// Bank of control registers with registered read port
`timescale 1ns/100ps
`default_nettype none
module ctrl_reg_bank
  import loader_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [WORD_W-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [WORD_W-1:0] rd_data_o
);
  logic [WORD_W-1:0] entry [REG_COUNT];

  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_entry
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          entry[g] <= WORD_RESET;
        end else if (wr_en_i && wr_addr_i == ADDR_W'(g)) begin
          entry[g] <= wr_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= WORD_RESET;
    end else begin
      rd_data_o <= entry[rd_addr_i];
    end
  end
endmodule : ctrl_reg_bank
`default_nettype wire

// ---- host_model.sv ----
// Host side of the three-wire link: serial clock, data and load strobe
`timescale 1ns/100ps
`default_nettype none
module host_model (
  output logic sclk_o,
  output logic data_o,
  output logic strobe_o
);
  initial begin
    sclk_o = 1'b0;
    data_o = 1'b0;
    strobe_o = 1'b0;
  end
  // Clock runs only inside a frame, 64 ns period
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      data_o = w[i];
      #16 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
      #16;
    end
    // Released line must not look like a held bit
    data_o = ~w[0];
    #40 strobe_o = 1'b1;
  endtask : send
  task automatic drop_strobe;
    strobe_o = 1'b0;
  endtask : drop_strobe
endmodule : host_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the three-wire register loader
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import loader_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, sdata, strobe;
  logic chip_enable = 1'b0;
  logic lock_detect = 1'b0;
  logic [ADDR_W-1:0] reg_sel = 3'h0;
  logic [WORD_W-1:0] reg_data;
  logic [ADDR_W-1:0] load_addr;
  logic load_done, powered_up, pump_oe, lock_ind;
  int mismatches = 0;
  int cmp_count = 0;
  always #25 mclk_i = ~mclk_i;
  host_model hm (.sclk_o(sclk), .data_o(sdata), .strobe_o(strobe));
  three_wire_register_loader dut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sclk_i(sclk),
    .serial_data_i(sdata),
    .load_strobe_i(strobe),
    .chip_enable_i(chip_enable),
    .lock_detect_i(lock_detect),
    .reg_sel_i(reg_sel),
    .reg_data_o(reg_data),
    .load_done_o(load_done),
    .load_addr_o(load_addr),
    .powered_up_o(powered_up),
    .pump_output_oe_o(pump_oe),
    .lock_indicator_o(lock_ind)
  );
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Shift a word, strobe it, then read the target register back
  task automatic load_word(input logic [31:0] w);
    logic seen;
    seen = 1'b0;
    hm.send(w);
    for (int n = 0; n < 12 && !seen; n++) begin
      @(negedge mclk_i);
      seen = (load_done === 1'b1);
    end
    check("load_done", 32'h1, {31'h0, seen});
    check("load_addr", {29'h0, w[2:0]}, {29'h0, load_addr});
    hm.drop_strobe;
    reg_sel = w[2:0];
    repeat (3) @(negedge mclk_i);
    check("reg_data", w, reg_data);
  endtask : load_word
  task automatic scen_loads;
    logic [2:0] a;
    for (int i = 0; i < 8; i++) begin
      a = 3'(i);
      load_word({8'hc3, 5'h0, a, 13'h12c0, a});
    end
  endtask : scen_loads
  task automatic settle(input logic ce, input logic lk);
    @(negedge mclk_i);
    chip_enable = ce;
    lock_detect = lk;
    repeat (4) @(negedge mclk_i);
  endtask : settle
  task automatic scen_power;
    settle(1'b1, 1'b1);
    check("powered_up", 32'h1, {31'h0, powered_up});
    check("lock_ind", 32'h1, {31'h0, lock_ind});
    settle(1'b0, 1'b1);
    check("powered_up", 32'h0, {31'h0, powered_up});
    check("pump_oe", 32'h0, {31'h0, pump_oe});
    settle(1'b1, 1'b0);
    check("pump_oe", 32'h1, {31'h0, pump_oe});
    check("lock_ind", 32'h0, {31'h0, lock_ind});
    // Power-down bit keeps the part off despite enable
    load_word(32'h0000_0022);
    check("pump_oe", 32'h0, {31'h0, pump_oe});
    load_word(32'h0000_0002);
    check("powered_up", 32'h1, {31'h0, powered_up});
  endtask : scen_power
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    scen_loads;
    scen_power;
    give_verdict;
  end
  initial begin
    #200000;
    mismatches++;
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
